// file: logic/csps_defs.svh
`ifndef CSPS_DEFS_SVH
`define CSPS_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CSPS_CLK_MHZ          200
`define CSPS_OFF_TIME_MS      1000
`define CSPS_OFF_CYCLES       (`CSPS_OFF_TIME_MS * 1000 * `CSPS_CLK_MHZ)
`define CSPS_DEB_CYCLES       4
`define CSPS_CNT_W            32

// ----------------------------------------------------------------------------
// Socket power levels
// ----------------------------------------------------------------------------
`define CSPS_PWR_OFF_LEVEL    1'b1
`define CSPS_PWR_ON_LEVEL     1'b0

`endif

// file: logic/csps_pkg.sv
package csps_pkg;

    typedef enum logic [2:0] {
        CSPS_ST_RESET,
        CSPS_ST_IDLE,
        CSPS_ST_CYCLE_OFF,
        CSPS_ST_READY
    } csps_state_t;

    typedef struct packed {
        logic card_present;
        logic cycling;
        logic card_ready;
    } csps_status_t;

endpackage : csps_pkg

// file: logic/csps_detect.sv
`timescale 1ns/1ps
`include "csps_defs.svh"

// Qualifies the two card-detect inputs: present only when both are low
// for DEB_CYCLES consecutive clocks; absent at once if either goes high.
module csps_detect #(
    parameter int DEB_CYCLES = `CSPS_DEB_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic card_detect_a_n,
    input  wire logic card_detect_b_n,
    output logic      present
);

    localparam int CW = $clog2(DEB_CYCLES + 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          present_ff;
    logic          nxt_present;
    logic          both_low;

    always_comb begin
        both_low    = ~card_detect_a_n & ~card_detect_b_n;
        nxt_cnt     = cnt_ff;
        nxt_present = present_ff;
        if (!both_low) begin
            nxt_cnt     = '0;
            nxt_present = 1'b0;
        end else if (cnt_ff == CW'(DEB_CYCLES - 1)) begin
            nxt_present = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff     <= '0;
            present_ff <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            present_ff <= nxt_present;
        end
    end

    assign present = present_ff;

endmodule : csps_detect

// file: logic/csps_seq.sv
`timescale 1ns/1ps
`include "csps_defs.svh"

// Contract
// - The socket power output is active low: low powers the socket, high removes power.
// - After reset is released the sequencer turns socket power on.
// - A card counts as inserted only when both card-detect inputs are low together.
// - On a valid insertion power is removed for about one second and then re-applied.
// - Every removal and reinsertion while powered repeats the full power cycle.
// - The controller may identify device 0 and 1 and choose their transfer modes.
// - Hardware neither drives nor interprets the passed-diagnostic or device-active lines.
module csps_seq #(
    parameter int OFF_CYCLES = `CSPS_OFF_CYCLES,
    parameter int DEB_CYCLES = `CSPS_DEB_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  card_detect_a_n,
    input  wire logic                  card_detect_b_n,
    output logic                       socket_power_ctl_pin_n,
    output logic                       ide_mode_strap_n,
    output csps_pkg::csps_status_t     status
);

    // ------------------------------------------------------------------------
    // Card detection
    // ------------------------------------------------------------------------
    logic present;

    csps_detect #(
        .DEB_CYCLES (DEB_CYCLES)
    ) csps_detect_inst (
        .clk             (clk),
        .rst             (rst),
        .card_detect_a_n (card_detect_a_n),
        .card_detect_b_n (card_detect_b_n),
        .present         (present)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    localparam int CW = `CSPS_CNT_W;

    csps_pkg::csps_state_t  state_ff;
    csps_pkg::csps_state_t  nxt_state;
    logic [CW-1:0]          cnt_ff;
    logic [CW-1:0]          nxt_cnt;
    logic                   pwr_n_ff;
    logic                   nxt_pwr_n;
    csps_pkg::csps_status_t status_ff;
    csps_pkg::csps_status_t nxt_status;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_pwr_n = pwr_n_ff;
        case (state_ff)
            csps_pkg::CSPS_ST_RESET: begin
                nxt_pwr_n = `CSPS_PWR_ON_LEVEL;
                nxt_state = csps_pkg::CSPS_ST_IDLE;
            end
            csps_pkg::CSPS_ST_IDLE: begin
                nxt_pwr_n = `CSPS_PWR_ON_LEVEL;
                if (present) begin
                    nxt_pwr_n = `CSPS_PWR_OFF_LEVEL;
                    nxt_cnt   = '0;
                    nxt_state = csps_pkg::CSPS_ST_CYCLE_OFF;
                end
            end
            csps_pkg::CSPS_ST_CYCLE_OFF: begin
                nxt_pwr_n = `CSPS_PWR_OFF_LEVEL;
                if (!present) begin
                    nxt_pwr_n = `CSPS_PWR_ON_LEVEL;
                    nxt_state = csps_pkg::CSPS_ST_IDLE;
                end else if (cnt_ff == CW'(OFF_CYCLES - 1)) begin
                    nxt_pwr_n = `CSPS_PWR_ON_LEVEL;
                    nxt_state = csps_pkg::CSPS_ST_READY;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
            csps_pkg::CSPS_ST_READY: begin
                nxt_pwr_n = `CSPS_PWR_ON_LEVEL;
                if (!present) begin
                    nxt_state = csps_pkg::CSPS_ST_IDLE;
                end
            end
            default: begin
                nxt_pwr_n = `CSPS_PWR_OFF_LEVEL;
                nxt_state = csps_pkg::CSPS_ST_RESET;
            end
        endcase
        nxt_status.card_present = present;
        nxt_status.cycling      = (nxt_state == csps_pkg::CSPS_ST_CYCLE_OFF);
        nxt_status.card_ready   = (nxt_state == csps_pkg::CSPS_ST_READY);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff  <= csps_pkg::CSPS_ST_RESET;
            cnt_ff    <= '0;
            pwr_n_ff  <= `CSPS_PWR_OFF_LEVEL;
            status_ff <= '0;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            pwr_n_ff  <= nxt_pwr_n;
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Strap is held asserted so the card latches direct-disk mode on power-up
    logic strap_n_ff;

    always_ff @(posedge clk) begin
        strap_n_ff <= 1'b0;
    end

    assign socket_power_ctl_pin_n = pwr_n_ff;
    assign ide_mode_strap_n       = strap_n_ff;
    assign status                 = status_ff;

    // Passed-diagnostic and device-active lines have no port here
    // Identify and transfer-mode choice stay with firmware once card_ready is up

endmodule : csps_seq

// file: bench/csps_seq_checker.sv
`timescale 1ns/1ps
`include "csps_defs.svh"
module csps_seq_checker #(
    parameter int OFF_CYCLES = `CSPS_OFF_CYCLES
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   card_detect_a_n,
    input wire logic                   card_detect_b_n,
    input wire logic                   socket_power_ctl_pin_n,
    input wire logic                   ide_mode_strap_n,
    input wire csps_pkg::csps_status_t status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Counts edges spent with socket power removed
    logic [31:0] off_cnt_ff;
    logic [31:0] nxt_off_cnt;
    always_comb nxt_off_cnt = socket_power_ctl_pin_n ? off_cnt_ff + 32'h1 : 32'h0;
    always_ff @(posedge clk) off_cnt_ff <= rst ? 32'h0 : nxt_off_cnt;
    a_power_after_rst: assert property ($fell(rst) |-> ##1 !socket_power_ctl_pin_n)
        else $error("socket power not applied after reset");
    a_removal_idle: assert property ((card_detect_a_n | card_detect_b_n) |->
        ##2 (!socket_power_ctl_pin_n && !status.card_ready)) else $error("removal not handled");
    a_cycle_cause: assert property ($rose(socket_power_ctl_pin_n) |->
        !$past(card_detect_a_n | card_detect_b_n, 2)) else $error("power cut without card");
    a_off_length: assert property ($rose(status.card_ready) |-> off_cnt_ff == OFF_CYCLES)
        else $error("power off time wrong");
    a_ready_powered: assert property (status.card_ready |-> !socket_power_ctl_pin_n)
        else $error("ready card unpowered");
    a_cycling_off: assert property (status.cycling |-> socket_power_ctl_pin_n)
        else $error("power on while cycling");
    a_cycle_present: assert property ($rose(status.cycling) |-> status.card_present)
        else $error("cycle without card present");
    a_strap_held: assert property (!ide_mode_strap_n)
        else $error("mode strap released");
endmodule : csps_seq_checker

// file: bench/csps_card_model.sv
`timescale 1ns/1ps
module csps_card_model (
    input  wire logic clk,
    input  wire logic seat_a,
    input  wire logic seat_b,
    input  wire logic power_n,
    input  wire logic strap_n,
    output logic      card_detect_a_n,
    output logic      card_detect_b_n,
    output logic      direct_mode
);
    logic cut_ff;
    // Only mode state is modelled: no memory or attribute space is offered
    // Transfers stay 16 bits wide; no set-features path exists here
    // Device select pin is taken as grounded, so the card is device 0
    // Contacts ground the lines; pull-ups hold them high when unseated
    assign card_detect_a_n = !seat_a;
    assign card_detect_b_n = !seat_b;
    // Strap counts only on a power-up that follows a cut with the card seated
    always_ff @(posedge clk) begin
        cut_ff <= (seat_a && seat_b) && (power_n || cut_ff);
        direct_mode <= (seat_a && seat_b && !power_n) && (direct_mode || (cut_ff && !strap_n));
    end
endmodule : csps_card_model

// file: bench/test_card_socket_power_sequencer.sv
`timescale 1ns/1ps
module test_card_socket_power_sequencer;
    localparam int OFF_CYCLES = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic seat_a = 1'b0;
    logic seat_b = 1'b0;
    logic cd_a_n, cd_b_n, pwr_n, strap_n, direct_mode;
    csps_pkg::csps_status_t status;
    int miscompares = 0;
    int checked = 0;
    int n;
    // Seat a, seat b, cycle expected
    logic [2:0] rows [4] = '{3'b000, 3'b100, 3'b010, 3'b111};
    always #2.5 clk = ~clk;
    csps_seq #(.OFF_CYCLES(OFF_CYCLES)) csps_seq_inst (.clk(clk), .rst(rst),
        .card_detect_a_n(cd_a_n), .card_detect_b_n(cd_b_n), .socket_power_ctl_pin_n(pwr_n),
        .ide_mode_strap_n(strap_n), .status(status));
    csps_card_model csps_card_model_inst (.clk(clk), .seat_a(seat_a), .seat_b(seat_b),
        .power_n(pwr_n), .strap_n(strap_n), .card_detect_a_n(cd_a_n),
        .card_detect_b_n(cd_b_n), .direct_mode(direct_mode));
    task automatic check(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task automatic seat(input logic a, input logic b, input int wait_n);
        @(posedge clk);
        seat_a <= a;
        seat_b <= b;
        repeat (wait_n) @(posedge clk);
        #1;
    endtask : seat
    task automatic wait_ready(output int cnt);
        for (cnt = 0; cnt < 80 && status.card_ready !== 1'b1; cnt++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_ready
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("pwr_in_reset", 1'b1, pwr_n);
        @(posedge clk);
        #1;
        check("pwr_after_reset", 1'b0, pwr_n);
        foreach (rows[i]) begin
            seat(rows[i][2], rows[i][1], 10);
            check("cycling", rows[i][0], status.cycling);
            check("pwr_cut", rows[i][0], pwr_n);
            seat(1'b0, 1'b0, 3);
            check("pwr_abort", 1'b0, pwr_n);
        end
        seat(1'b1, 1'b1, 0);
        wait_ready(n);
        check("off_time", 1'b1, n >= OFF_CYCLES && n <= OFF_CYCLES + 8);
        check("card_present", 1'b1, status.card_present);
        check("strap", 1'b0, strap_n);
        @(posedge clk);
        #1;
        check("direct_mode", 1'b1, direct_mode);
        seat(1'b1, 1'b0, 3);
        check("ready_removed", 1'b0, status.card_ready);
        check("pwr_removed", 1'b0, pwr_n);
        seat(1'b1, 1'b1, 0);
        wait_ready(n);
        @(posedge clk);
        #1;
        check("recycle", 1'b1, direct_mode && n >= OFF_CYCLES);
        tally_and_finish();
    end
    initial begin
        #3000;
        miscompares++;
        tally_and_finish();
    end
endmodule : test_card_socket_power_sequencer
bind csps_seq csps_seq_checker #(.OFF_CYCLES(OFF_CYCLES)) csps_seq_checker_inst (.clk(clk),
    .rst(rst), .card_detect_a_n(card_detect_a_n), .card_detect_b_n(card_detect_b_n),
    .socket_power_ctl_pin_n(socket_power_ctl_pin_n), .ide_mode_strap_n(ide_mode_strap_n),
    .status(status));
